// file: core/gpc_defs.vh
/*
 Register offsets, field positions, reset values and mode codes for the pin
 configuration block. Assumes inclusion by bare name from the design file.
*/
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH

`define GPC_ADDR_MODE_LO      8'h00
`define GPC_ADDR_MODE_HI      8'h04
`define GPC_ADDR_CTRL         8'h08
`define GPC_ADDR_DOUT         8'h0C
`define GPC_ADDR_DOUT_TGL     8'h10
`define GPC_ADDR_DIN          8'h14
`define GPC_ADDR_PINLOCK      8'h18
`define GPC_ADDR_OVTDIS       8'h1C
`define GPC_ADDR_LOCK         8'h20
`define GPC_ADDR_WAKE_EN      8'h24
`define GPC_ADDR_WAKE_POL     8'h28
`define GPC_ADDR_FLAG         8'h2C
`define GPC_ADDR_FLAG_SET     8'h30
`define GPC_ADDR_FLAG_CLR     8'h34
`define GPC_ADDR_EVENT_EN     8'h38

`define GPC_UNLOCK_KEY        16'hA534
`define GPC_WAKE_BIT_BASE     16

`define GPC_CTRL_DRV_LSB      0
`define GPC_CTRL_SLEW_LSB     4
`define GPC_CTRL_INPUT_OFF_NORMAL_BIT   12
`define GPC_CTRL_DRV_ALT_LSB  16
`define GPC_CTRL_SLEW_ALT_LSB 20
`define GPC_CTRL_DIS_ALT_BIT  28
`define GPC_CTRL_MASK         32'h1077_1077
`define GPC_CTRL_RESET        32'h0000_0000

`define GPC_MODE_DISABLED     4'h0
`define GPC_MODE_INPUT        4'h1
`define GPC_MODE_INPUTPULL    4'h2
`define GPC_MODE_INPUT_PF     4'h3
`define GPC_MODE_PP           4'h4
`define GPC_MODE_PP_ALT       4'h5
`define GPC_MODE_OS           4'h6
`define GPC_MODE_OS_PD        4'h7
`define GPC_MODE_OD           4'h8
`define GPC_MODE_OD_F         4'h9
`define GPC_MODE_OD_PU        4'hA
`define GPC_MODE_OD_PU_F      4'hB
`define GPC_MODE_OD_ALT       4'hC
`define GPC_MODE_OD_ALT_F     4'hD
`define GPC_MODE_OD_ALT_PU    4'hE
`define GPC_MODE_OD_ALT_PU_F  4'hF

`endif

// file: core/gpc_pin_config.v
/*
 One general purpose I/O port: per-pin mode decode into pad controls, port
 control selection, configuration lock, per-pin locks, over-voltage disable
 and deep-sleep wake-up enable, polarity and flags.
 Assumes a simple register port with read data one cycle after the read strobe,
 and pad inputs and wake pins that arrive asynchronously.
*/
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "gpc_defs.vh"

// Function
// [R1] Disabled pull-up on dout; input filter on dout
// [R2] Pulled-filtered input with dout 1: pull-up, filter
// [R3] Push-pull drives pin from output register
// [R4] Alternate push-pull uses alternate port settings
// [R5] Open-source drives high; pull-down off when high
// [R6] Open-drain drives low; pull-up off when low
// [R7] Open-drain modes cover all feature combinations
// [R8] Disabled mode turns drivers off
// [R9] Input enabled unless disabled or port-disable set
// [R10] Alternate modes use alternate port control fields
// [R11] Drive strength is per port, two sets
// [R12] Over-voltage tolerance on at reset, per-pin disable
// [R13] Non-key lock write protects configuration registers
// [R14] Unlock key write reopens configuration registers
// [R15] Cleared pin lock blocks that pin's writes
// [R16] Pin lock clears stick until reset
// [R17] Wake requires enable; polarity from level register
// [R18] Wake-enabled pins get filter during deep sleep
// [R19] Flag-clear write resets wake logic and flag
// [R20] Flag register records waking pin
// [R21] Wake pin k uses bit 16 plus k
// [R22] Software configures wake pins as filtered inputs
// [R23] Four-bit mode fields, table order codes
module gpc_pin_config #(
   parameter NPIN  = 16,
   parameter NWAKE = 4
) (
   input  wire              sys_clk_i,
   input  wire              sys_rst_i,
   input  wire              clk_en_i,
   input  wire [7:0]        reg_addr_i,
   input  wire [31:0]       reg_wdata_i,
   input  wire              reg_wr_i,
   input  wire              reg_rd_i,
   output reg  [31:0]       reg_rdata_o,
   input  wire [NPIN-1:0]   pad_in_i,
   input  wire [NWAKE-1:0]  wake_pin_i,
   input  wire              deep_sleep_i,
   output reg  [NPIN-1:0]   pad_out_o,
   output reg  [NPIN-1:0]   pad_oe_o,
   output reg  [NPIN-1:0]   pad_in_en_o,
   output reg  [NPIN-1:0]   pad_pull_up_o,
   output reg  [NPIN-1:0]   pad_pull_down_o,
   output reg  [NPIN-1:0]   pad_filter_o,
   output reg  [NPIN-1:0]   pad_alt_sel_o,
   output reg  [NPIN-1:0]   pad_ovt_en_o,
   output reg  [2:0]        drive_level_normal_o,
   output reg  [2:0]        drive_level_second_set_o,
   output reg  [2:0]        edge_rate_normal_o,
   output reg  [2:0]        edge_rate_second_set_o,
   output reg               wake_req_o
);

   reg  [4*NPIN-1:0] pin_mode_field;
   reg  [31:0]       port_control_reg;
   reg  [NPIN-1:0]   port_output_reg;
   reg  [NPIN-1:0]   per_pin_lock_reg;
   reg  [NPIN-1:0]   overvoltage_disable_reg;
   reg               cfg_locked;
   reg  [NWAKE-1:0]  deep_sleep_wake_enable_reg;
   reg  [NWAKE-1:0]  wake_polarity_reg;
   reg  [NWAKE-1:0]  wake_flag;
   reg  [NWAKE-1:0]  event_enable_reg;
   reg  [NPIN-1:0]   pad_sync1;
   reg  [NPIN-1:0]   pad_sync2;
   reg  [NWAKE-1:0]  wake_sync1;
   reg  [NWAKE-1:0]  wake_sync2;
   reg  [NPIN-1:0]   din;

   wire wr_mode_lo = reg_wr_i && (reg_addr_i == `GPC_ADDR_MODE_LO);
   wire wr_mode_hi = reg_wr_i && (reg_addr_i == `GPC_ADDR_MODE_HI);
   wire wr_ctrl    = reg_wr_i && (reg_addr_i == `GPC_ADDR_CTRL);
   wire wr_dout    = reg_wr_i && (reg_addr_i == `GPC_ADDR_DOUT);
   wire wr_tgl     = reg_wr_i && (reg_addr_i == `GPC_ADDR_DOUT_TGL);
   wire wr_plock   = reg_wr_i && (reg_addr_i == `GPC_ADDR_PINLOCK);
   wire wr_ovt     = reg_wr_i && (reg_addr_i == `GPC_ADDR_OVTDIS);
   wire wr_lock    = reg_wr_i && (reg_addr_i == `GPC_ADDR_LOCK);
   wire wr_wen     = reg_wr_i && (reg_addr_i == `GPC_ADDR_WAKE_EN);
   wire wr_wpol    = reg_wr_i && (reg_addr_i == `GPC_ADDR_WAKE_POL);
   wire wr_fset    = reg_wr_i && (reg_addr_i == `GPC_ADDR_FLAG_SET);
   wire wr_fclr    = reg_wr_i && (reg_addr_i == `GPC_ADDR_FLAG_CLR);
   wire wr_ien     = reg_wr_i && (reg_addr_i == `GPC_ADDR_EVENT_EN);

   wire [NWAKE-1:0] wdata_wake  = reg_wdata_i[`GPC_WAKE_BIT_BASE +: NWAKE]; // [R21]
   wire [NWAKE-1:0] wake_active = ~(wake_sync2 ^ wake_polarity_reg);        // [R17]
   wire [NWAKE-1:0] wake_hit    = wake_active & deep_sleep_wake_enable_reg;  // [R17]

   // Mode registers, output register and per-pin over-voltage disable.
   genvar p;
   generate
      for (p = 0; p < NPIN; p = p + 1) begin : g_pin
         wire pin_open   = per_pin_lock_reg[p];
         wire mode_wr    = (p < 8) ? wr_mode_lo : wr_mode_hi;
         wire [3:0] mode = pin_mode_field[4*p +: 4];
         always @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               pin_mode_field[4*p +: 4]   <= `GPC_MODE_DISABLED;
               port_output_reg[p]         <= 1'b0;
               overvoltage_disable_reg[p] <= 1'b0; // [R12]
            end else if (clk_en_i) begin
               if (mode_wr && !cfg_locked && pin_open) begin // [R13] [R15]
                  pin_mode_field[4*p +: 4] <= reg_wdata_i[4*(p%8) +: 4]; // [R23]
               end
               if (wr_dout && pin_open) begin // [R15]
                  port_output_reg[p] <= reg_wdata_i[p];
               end else if (wr_tgl && pin_open && reg_wdata_i[p]) begin // [R15]
                  port_output_reg[p] <= ~port_output_reg[p];
               end
               if (wr_ovt && !cfg_locked && pin_open) begin // [R13] [R15]
                  overvoltage_disable_reg[p] <= reg_wdata_i[p]; // [R12]
               end
            end
         end

         // Pad controls are registered so that the pad sees no decode glitches.
         always @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               pad_out_o[p]       <= 1'b0;
               pad_oe_o[p]        <= 1'b0;
               pad_in_en_o[p]     <= 1'b0;
               pad_pull_up_o[p]   <= 1'b0;
               pad_pull_down_o[p] <= 1'b0;
               pad_filter_o[p]    <= 1'b0;
               pad_alt_sel_o[p]   <= 1'b0;
               pad_ovt_en_o[p]    <= 1'b1;
            end else if (clk_en_i) begin
               pad_out_o[p]       <= port_output_reg[p];
               pad_oe_o[p]        <= 1'b0;
               pad_pull_up_o[p]   <= 1'b0;
               pad_pull_down_o[p] <= 1'b0;
               pad_filter_o[p]    <= 1'b0;
               pad_alt_sel_o[p]   <= (mode == `GPC_MODE_PP_ALT) || (mode[3:2] == 2'b11); // [R10]
               pad_ovt_en_o[p]    <= ~overvoltage_disable_reg[p]; // [R12]
               if (mode == `GPC_MODE_DISABLED) begin
                  pad_in_en_o[p] <= 1'b0; // [R8] [R9]
               end else if ((mode == `GPC_MODE_PP_ALT) || (mode[3:2] == 2'b11)) begin
                  pad_in_en_o[p] <= ~port_control_reg[`GPC_CTRL_DIS_ALT_BIT]; // [R9] [R10]
               end else begin
                  pad_in_en_o[p] <= ~port_control_reg[`GPC_CTRL_INPUT_OFF_NORMAL_BIT]; // [R9]
               end
               case (mode)
                  `GPC_MODE_DISABLED: begin
                     pad_pull_up_o[p] <= port_output_reg[p]; // [R1] [R8]
                  end
                  `GPC_MODE_INPUT: begin
                     pad_filter_o[p] <= port_output_reg[p]; // [R1]
                  end
                  `GPC_MODE_INPUTPULL: begin
                     pad_pull_up_o[p]   <= port_output_reg[p];
                     pad_pull_down_o[p] <= ~port_output_reg[p];
                  end
                  `GPC_MODE_INPUT_PF: begin
                     pad_pull_up_o[p]   <= port_output_reg[p]; // [R2]
                     pad_pull_down_o[p] <= ~port_output_reg[p];
                     pad_filter_o[p]    <= 1'b1; // [R2]
                  end
                  `GPC_MODE_PP, `GPC_MODE_PP_ALT: begin
                     pad_oe_o[p] <= 1'b1; // [R3] [R4]
                  end
                  `GPC_MODE_OS, `GPC_MODE_OS_PD: begin
                     pad_oe_o[p]        <= port_output_reg[p]; // [R5]
                     pad_pull_down_o[p] <= (mode == `GPC_MODE_OS_PD) && !port_output_reg[p]; // [R5]
                  end
                  default: begin
                     // Open-drain family: bit 0 filter, bit 1 pull-up, bit 2 alternate.
                     pad_oe_o[p]      <= ~port_output_reg[p]; // [R6] [R7]
                     pad_pull_up_o[p] <= mode[1] && port_output_reg[p]; // [R6] [R7]
                     pad_filter_o[p]  <= mode[0]; // [R7]
                  end
               endcase
               if (p < NWAKE) begin
                  if (deep_sleep_i && deep_sleep_wake_enable_reg[p % NWAKE]) begin
                     pad_filter_o[p] <= 1'b1; // [R18]
                  end
               end
            end
         end
      end
   endgenerate

   // Port control, locks, wake-up configuration and flags.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         port_control_reg           <= `GPC_CTRL_RESET;
         per_pin_lock_reg           <= {NPIN{1'b1}};
         cfg_locked                 <= 1'b0;
         deep_sleep_wake_enable_reg <= {NWAKE{1'b0}};
         wake_polarity_reg          <= {NWAKE{1'b0}};
         wake_flag                  <= {NWAKE{1'b0}};
         event_enable_reg           <= {NWAKE{1'b0}};
         wake_req_o                 <= 1'b0;
      end else if (clk_en_i) begin
         if (wr_lock) begin
            cfg_locked <= (reg_wdata_i[15:0] != `GPC_UNLOCK_KEY); // [R13] [R14]
         end
         if (wr_ctrl && !cfg_locked) begin // [R13]
            port_control_reg <= reg_wdata_i & `GPC_CTRL_MASK;
         end
         if (wr_plock && !cfg_locked) begin // [R13]
            per_pin_lock_reg <= per_pin_lock_reg & reg_wdata_i[NPIN-1:0]; // [R16]
         end
         if (wr_wen) begin
            deep_sleep_wake_enable_reg <= wdata_wake; // [R21]
         end
         if (wr_wpol) begin
            wake_polarity_reg <= wdata_wake; // [R21]
         end
         if (wr_ien) begin
            event_enable_reg <= wdata_wake; // [R21]
         end
         // A wake event in the same cycle as a clear keeps its flag set.
         wake_flag <= (wake_flag & ~({NWAKE{wr_fclr}} & wdata_wake)) // [R19]
                      | ({NWAKE{wr_fset}} & wdata_wake)
                      | wake_hit; // [R20]
         wake_req_o <= |wake_hit; // [R17]
      end
   end

   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pad_sync1                <= {NPIN{1'b0}};
         pad_sync2                <= {NPIN{1'b0}};
         wake_sync1               <= {NWAKE{1'b0}};
         wake_sync2               <= {NWAKE{1'b0}};
         din                      <= {NPIN{1'b0}};
         drive_level_normal_o     <= 3'h0;
         drive_level_second_set_o <= 3'h0;
         edge_rate_normal_o       <= 3'h0;
         edge_rate_second_set_o   <= 3'h0;
      end else if (clk_en_i) begin
         pad_sync1  <= pad_in_i;
         pad_sync2  <= pad_sync1;
         wake_sync1 <= wake_pin_i;
         wake_sync2 <= wake_sync1;
         din        <= pad_sync2 & pad_in_en_o;
         drive_level_normal_o     <= port_control_reg[`GPC_CTRL_DRV_LSB +: 3]; // [R11]
         drive_level_second_set_o <= port_control_reg[`GPC_CTRL_DRV_ALT_LSB +: 3]; // [R11]
         edge_rate_normal_o       <= port_control_reg[`GPC_CTRL_SLEW_LSB +: 3];
         edge_rate_second_set_o   <= port_control_reg[`GPC_CTRL_SLEW_ALT_LSB +: 3]; // [R10]
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads as zero.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (clk_en_i) begin
         reg_rdata_o <= 32'h0000_0000;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `GPC_ADDR_MODE_LO:  reg_rdata_o <= pin_mode_field[31:0];
               `GPC_ADDR_MODE_HI:  reg_rdata_o <= pin_mode_field[4*NPIN-1:32];
               `GPC_ADDR_CTRL:     reg_rdata_o <= port_control_reg;
               `GPC_ADDR_DOUT:     reg_rdata_o[NPIN-1:0] <= port_output_reg;
               `GPC_ADDR_DIN:      reg_rdata_o[NPIN-1:0] <= din;
               `GPC_ADDR_PINLOCK:  reg_rdata_o[NPIN-1:0] <= per_pin_lock_reg;
               `GPC_ADDR_OVTDIS:   reg_rdata_o[NPIN-1:0] <= overvoltage_disable_reg;
               `GPC_ADDR_LOCK:     reg_rdata_o[0] <= cfg_locked;
               `GPC_ADDR_WAKE_EN:
                  reg_rdata_o[`GPC_WAKE_BIT_BASE +: NWAKE] <= deep_sleep_wake_enable_reg;
               `GPC_ADDR_WAKE_POL:
                  reg_rdata_o[`GPC_WAKE_BIT_BASE +: NWAKE] <= wake_polarity_reg;
               `GPC_ADDR_FLAG:     reg_rdata_o[`GPC_WAKE_BIT_BASE +: NWAKE] <= wake_flag; // [R20]
               `GPC_ADDR_EVENT_EN:
                  reg_rdata_o[`GPC_WAKE_BIT_BASE +: NWAKE] <= event_enable_reg;
               default:            reg_rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// file: verif/gpc_pad_model.sv
/*
 Behavioural model of the package pins of one port and the board behind them.
 Assumes the pad controls of gpc_pin_config and the same single clock.
*/
`timescale 1ns/1ps
module gpc_pad_model #(
   parameter NPIN = 16
) (
   input  wire logic            sys_clk_i,
   input  wire logic [NPIN-1:0] drv_out_i,
   input  wire logic [NPIN-1:0] drv_oe_i,
   input  wire logic [NPIN-1:0] pull_up_i,
   input  wire logic [NPIN-1:0] pull_down_i,
   output wire logic [NPIN-1:0] pad_level_o
);
   logic [NPIN-1:0] last = '0;
   // A pin nobody drives or pulls floats, so it shows the inverse of its last level.
   // This keeps a reader from relying on a value the simulator happened to pick.
   assign pad_level_o = (drv_oe_i & drv_out_i) | (~drv_oe_i & pull_up_i)
                      | (~drv_oe_i & ~pull_up_i & ~pull_down_i & ~last);
   always @(posedge sys_clk_i) begin
      last <= pad_level_o;
   end
endmodule

// file: verif/gpc_pin_config_chk.sv
/*
 Port checker for the pin configuration block.
 Assumes it is bound to gpc_pin_config and sees only its ports.
*/
`timescale 1ns/1ps
`include "gpc_defs.vh"
module gpc_pin_config_chk #(
   parameter NPIN  = 16,
   parameter NWAKE = 4
) (
   input wire logic             sys_clk_i,
   input wire logic             sys_rst_i,
   input wire logic             clk_en_i,
   input wire logic [7:0]       reg_addr_i,
   input wire logic [31:0]      reg_wdata_i,
   input wire logic             reg_wr_i,
   input wire logic             reg_rd_i,
   input wire logic [31:0]      reg_rdata_o,
   input wire logic [NWAKE-1:0] wake_pin_i,
   input wire logic             deep_sleep_i,
   input wire logic [NPIN-1:0]  pad_out_o,
   input wire logic [NPIN-1:0]  pad_oe_o,
   input wire logic [NPIN-1:0]  pad_pull_up_o,
   input wire logic [NPIN-1:0]  pad_pull_down_o,
   input wire logic [NPIN-1:0]  pad_filter_o,
   input wire logic [NPIN-1:0]  pad_ovt_en_o,
   input wire logic [2:0]       drive_level_normal_o,
   input wire logic [2:0]       edge_rate_second_set_o,
   input wire logic             wake_req_o
);
   localparam int WB = `GPC_WAKE_BIT_BASE;
   logic        lk;
   logic [31:0] wen;
   logic [31:0] wpol;
   wire         act = |(wen[WB +: NWAKE] & ~(wake_pin_i ^ wpol[WB +: NWAKE]));
   wire         cw  = reg_wr_i && reg_addr_i == `GPC_ADDR_CTRL;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i || !clk_en_i);
   // Shadow of the lock, wake enable and wake polarity registers, rebuilt from the bus traffic alone.
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         lk   <= 1'b0;
         wen  <= 32'h0000_0000;
         wpol <= 32'h0000_0000;
      end else if (clk_en_i && reg_wr_i) begin
         if (reg_addr_i == `GPC_ADDR_LOCK) lk <= reg_wdata_i[15:0] != `GPC_UNLOCK_KEY;
         if (reg_addr_i == `GPC_ADDR_WAKE_EN) wen <= reg_wdata_i;
         if (reg_addr_i == `GPC_ADDR_WAKE_POL) wpol <= reg_wdata_i;
      end
   end
   rst_ovt_a: assert property (
      $fell(sys_rst_i) |-> pad_ovt_en_o == {NPIN{1'b1}} && !wake_req_o)
      else $error("over-voltage tolerance not on after reset");
   os_pull_a: assert property (
      (pad_pull_down_o & pad_oe_o & pad_out_o) == '0)
      else $error("pull-down left on while driving high");
   od_pull_a: assert property (
      (pad_pull_up_o & pad_oe_o & ~pad_out_o) == '0)
      else $error("pull-up left on while driving low");
   ctrl_norm_a: assert property (
      cw && !lk |-> ##2 drive_level_normal_o == $past(reg_wdata_i[2:0], 2))
      else $error("normal drive level does not follow control write");
   ctrl_alt_a: assert property (
      cw && !lk |-> ##2 edge_rate_second_set_o == $past(reg_wdata_i[22:20], 2))
      else $error("second-set edge rate does not follow control write");
   ctrl_lock_a: assert property (
      cw && lk |-> ##1 $stable(drive_level_normal_o) [*2])
      else $error("control write took effect while locked");
   lock_rd_a: assert property (
      reg_rd_i && reg_addr_i == `GPC_ADDR_LOCK |=> reg_rdata_o == {31'h0, lk})
      else $error("lock status read back wrong");
   wake_on_a: assert property (
      act [*5] |-> wake_req_o)
      else $error("enabled active wake pin gives no request");
   wake_off_a: assert property (
      !act [*5] |-> !wake_req_o)
      else $error("wake request without an enabled active pin");
   sleep_filt_a: assert property (
      (deep_sleep_i && $stable(wen) && |wen[WB +: NWAKE]) [*2]
      |-> (pad_filter_o[NWAKE-1:0] & wen[WB +: NWAKE]) == wen[WB +: NWAKE])
      else $error("filter not forced on wake pin in deep sleep");
   wake_c: cover property ($rose(wake_req_o));
   lock_c: cover property (cw && lk);
   sleep_c: cover property (deep_sleep_i && |pad_filter_o);
endmodule
bind gpc_pin_config gpc_pin_config_chk #(.NPIN(NPIN), .NWAKE(NWAKE)) chk_i (
   .sys_clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .reg_rdata_o, .wake_pin_i, .deep_sleep_i, .pad_out_o, .pad_oe_o, .pad_pull_up_o,
   .pad_pull_down_o, .pad_filter_o, .pad_ovt_en_o, .drive_level_normal_o,
   .edge_rate_second_set_o, .wake_req_o);

// file: verif/gpc_pin_config_tb_top.sv
/*
 Self-checking bench for the pin configuration block, with a pin model.
 Assumes the register offsets and mode codes of gpc_defs.vh.
*/
`timescale 1ns/1ps
`include "gpc_defs.vh"
module gpc_pin_config_tb_top;
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        clk_en_i = 1'b1;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic        deep_sleep_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic [3:0]  wake_pin_i = 4'h0;
   wire  [31:0] reg_rdata_o;
   wire  [15:0] pad_out_o, pad_oe_o, pad_in_en_o, pad_pull_up_o, pad_pull_down_o;
   wire  [15:0] pad_filter_o, pad_alt_sel_o, pad_ovt_en_o, pad_level;
   wire  [2:0]  drive_level_normal_o, drive_level_second_set_o;
   wire  [2:0]  edge_rate_normal_o, edge_rate_second_set_o;
   wire         wake_req_o;
   wire  [6:0]  pin0 = {pad_oe_o[0], pad_out_o[0] & pad_oe_o[0], pad_in_en_o[0],
                         pad_pull_up_o[0], pad_pull_down_o[0], pad_filter_o[0], pad_alt_sel_o[0]};
   wire  [11:0] ctl = {drive_level_normal_o, edge_rate_normal_o,
                       drive_level_second_set_o, edge_rate_second_set_o};
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;
   gpc_pin_config uut (.sys_clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pad_in_i(pad_level), .wake_pin_i, .deep_sleep_i,
      .pad_out_o, .pad_oe_o, .pad_in_en_o, .pad_pull_up_o, .pad_pull_down_o, .pad_filter_o,
      .pad_alt_sel_o, .pad_ovt_en_o, .drive_level_normal_o, .drive_level_second_set_o,
      .edge_rate_normal_o, .edge_rate_second_set_o, .wake_req_o);
   gpc_pad_model pm (.sys_clk_i, .drv_out_i(pad_out_o), .drv_oe_i(pad_oe_o),
      .pull_up_i(pad_pull_up_o), .pull_down_i(pad_pull_down_o), .pad_level_o(pad_level));
   always #50 sys_clk_i = ~sys_clk_i;
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // The ceiling is several times the length of the planned sequence.
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         summarize;
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, e);
   endtask
   // Pad controls of one pin: oe, driven high, input, pull-up, pull-down, filter, alt.
   function logic [6:0] pexp(input logic [3:0] m, input logic d);
      logic pp, os, od;
      pp = m == 4'h4 || m == 4'h5;
      os = m == 4'h6 || m == 4'h7;
      od = m[3];
      pexp[6] = pp | (os & d) | (od & !d);
      pexp[5] = (pp | os) & d;
      pexp[4] = m != 4'h0;
      pexp[3] = ((m == 4'h0 || m == 4'h2 || m == 4'h3) & d) | (od & m[1] & d);
      pexp[2] = (m == 4'h2 || m == 4'h3 || m == 4'h7) & !d;
      pexp[1] = (m == 4'h1 & d) | m == 4'h3 | (od & m[0]);
      pexp[0] = m == 4'h5 | (od & m[2]);
   endfunction
   initial begin
      repeat (8) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      rd(`GPC_ADDR_PINLOCK, 32'h0000_FFFF);
      rd(`GPC_ADDR_MODE_LO, 32'h0000_0000);
      chk(32'(pad_ovt_en_o), 32'h0000_FFFF);
      $display("test reset done");
      for (int m = 0; m < 16; m++) begin
         for (int d = 0; d < 2; d++) begin
            wr(`GPC_ADDR_MODE_LO, 32'(m));
            wr(`GPC_ADDR_DOUT, 32'(d));
            w(1);
            chk(32'(pin0), 32'(pexp(4'(m), 1'(d))));
         end
      end
      wr(`GPC_ADDR_MODE_HI, 32'h4000_0000);
      wr(`GPC_ADDR_DOUT, 32'h0000_FFFF);
      w(4);
      // Disabled pins keep their input off, so only pins 0 and 15 show up here.
      rd(`GPC_ADDR_DIN, 32'h0000_8001);
      $display("test modes done");
      wr(`GPC_ADDR_CTRL, 32'hFFFF_FFFF);
      rd(`GPC_ADDR_CTRL, 32'h1077_1077);
      wr(`GPC_ADDR_MODE_LO, 32'h0000_0051);
      wr(`GPC_ADDR_CTRL, 32'h0053_1021);
      w(1);
      chk(32'(ctl), 32'h0000_029D);
      chk(32'(pad_in_en_o[1:0]), 32'h2);
      wr(`GPC_ADDR_CTRL, 32'h1053_0021);
      w(1);
      chk(32'(pad_in_en_o[1:0]), 32'h1);
      wr(`GPC_ADDR_OVTDIS, 32'h0000_0001);
      w(1);
      chk(32'(pad_ovt_en_o), 32'h0000_FFFE);
      $display("test port control done");
      wr(`GPC_ADDR_LOCK, 32'h0000_0000);
      rd(`GPC_ADDR_LOCK, 32'h0000_0001);
      wr(`GPC_ADDR_MODE_LO, 32'h0000_0000);
      wr(`GPC_ADDR_CTRL, 32'h0000_0000);
      wr(`GPC_ADDR_OVTDIS, 32'h0000_0000);
      wr(`GPC_ADDR_PINLOCK, 32'h0000_0000);
      rd(`GPC_ADDR_MODE_LO, 32'h0000_0051);
      rd(`GPC_ADDR_CTRL, 32'h1053_0021);
      rd(`GPC_ADDR_OVTDIS, 32'h0000_0001);
      rd(`GPC_ADDR_PINLOCK, 32'h0000_FFFF);
      wr(`GPC_ADDR_LOCK, 32'(`GPC_UNLOCK_KEY));
      rd(`GPC_ADDR_LOCK, 32'h0000_0000);
      wr(`GPC_ADDR_MODE_LO, 32'h0000_0000);
      rd(`GPC_ADDR_MODE_LO, 32'h0000_0000);
      $display("test lock done");
      wr(`GPC_ADDR_DOUT, 32'h0000_0000);
      wr(`GPC_ADDR_PINLOCK, 32'h0000_FFFE);
      wr(`GPC_ADDR_MODE_LO, 32'h0000_0044);
      rd(`GPC_ADDR_MODE_LO, 32'h0000_0040);
      wr(`GPC_ADDR_DOUT, 32'h0000_0003);
      rd(`GPC_ADDR_DOUT, 32'h0000_0002);
      wr(`GPC_ADDR_DOUT_TGL, 32'h0000_0003);
      rd(`GPC_ADDR_DOUT, 32'h0000_0000);
      wr(`GPC_ADDR_OVTDIS, 32'h0000_0000);
      rd(`GPC_ADDR_OVTDIS, 32'h0000_0001);
      wr(`GPC_ADDR_PINLOCK, 32'h0000_FFFF);
      rd(`GPC_ADDR_PINLOCK, 32'h0000_FFFE);
      @(posedge sys_clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      rd(`GPC_ADDR_PINLOCK, 32'h0000_FFFF);
      $display("test pin lock done");
      wr(`GPC_ADDR_WAKE_EN, 32'h0001_0000);
      deep_sleep_i <= 1'b1;
      w(3);
      chk(32'(pad_filter_o[0]), 32'h1);
      @(posedge sys_clk_i);
      deep_sleep_i <= 1'b0;
      wr(`GPC_ADDR_MODE_LO, 32'h0000_3333);
      wr(`GPC_ADDR_WAKE_POL, 32'h0001_0000);
      wr(`GPC_ADDR_FLAG_CLR, 32'h000F_0000);
      @(posedge sys_clk_i);
      wake_pin_i <= 4'h5;
      w(5);
      chk(32'(wake_req_o), 32'h1);
      rd(`GPC_ADDR_FLAG, 32'h0001_0000);
      @(posedge sys_clk_i);
      wake_pin_i <= 4'h0;
      w(5);
      chk(32'(wake_req_o), 32'h0);
      rd(`GPC_ADDR_FLAG, 32'h0001_0000);
      wr(`GPC_ADDR_FLAG_CLR, 32'h0001_0000);
      rd(`GPC_ADDR_FLAG, 32'h0000_0000);
      wr(`GPC_ADDR_WAKE_EN, 32'h0002_0000);
      w(5);
      rd(`GPC_ADDR_FLAG, 32'h0002_0000);
      wr(`GPC_ADDR_FLAG_SET, 32'h0004_0000);
      rd(`GPC_ADDR_FLAG, 32'h0006_0000);
      wr(`GPC_ADDR_EVENT_EN, 32'h000F_0000);
      rd(`GPC_ADDR_EVENT_EN, 32'h000F_0000);
      $display("test wake done");
      summarize;
   end
endmodule
